// ==== capture_timer.sv ====
// Capture timer core: 16-bit counter, two capture/compare registers,
// filtered capture inputs, one-shot output and a Wishbone register slave.
// Assumes asynchronous pins on the capture inputs and one clock domain.
`timescale 1ns/1ps
`include "capture_timer_consts.svh"
module capture_timer
   import capture_timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        capture_input_a_i,
   input  wire logic        capture_input_b_i,
   output logic             pulse_o,
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   ctrl_s       ctrl_reg;
   count_t      timer_count_value;
   count_t      capture_compare_reg_a;
   count_t      capture_compare_reg_b;
   logic [1:0]  status_reg;
   logic [1:0]  mask_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        pulse_reg;
   logic        irq_reg;
   logic        armed_reg;
   logic        started_reg;
   logic [1:0]  a_sync_reg;
   logic [1:0]  b_sync_reg;
   logic [2:0]  div_reg;
   logic        cclk_reg;
   logic        cap_a_pend_reg;
   logic        cap_b_pend_reg;
   logic        capture_irq_a;
   logic        capture_irq_b;
   logic        irq_a_pend_reg;
   logic        irq_b_pend_reg;
   logic        wr_fire;
   logic        rd_start;
   logic        run;
   logic        half_tick;
   logic        rise_tick;
   logic        fall_tick;
   logic        cnt_tick;
   logic        samp_en_a;
   edges_s      edges_a;
   edges_s      edges_b;
   logic        valid_a;
   logic        rev_a;
   logic        valid_b;
   logic        trig_cap_a;
   logic        trig_cap_b;
   logic        direct_irq_a;
   logic        os_mode_ok;
   logic        os_go;
   logic [2:0]  half_period;
   logic [31:0] rdata;
   logic [31:0] ctrl_wdata;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic edge_match(input logic [1:0] es, input edges_s e);
      logic hit;
      case (es)
         `CT_ES_FALL: hit = e.fall;
         `CT_ES_RISE: hit = e.rise;
         `CT_ES_BOTH: hit = e.rise | e.fall;
         default:     hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_match

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the strobe; writes land with ack

   assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign rd_start = wb_cyc_i & wb_stb_i & ~ack_reg;

   always_comb begin
      rdata = 32'h0000_0000;
      case (wb_adr_i)
         `CT_OFS_CTRL:   rdata[`CT_CTRL_W-1:0] = ctrl_reg;
         `CT_OFS_COUNT:  rdata[15:0] = timer_count_value;
         `CT_OFS_CAP_A:  rdata[15:0] = capture_compare_reg_a;
         `CT_OFS_CAP_B:  rdata[15:0] = capture_compare_reg_b;
         `CT_OFS_STATUS: rdata[1:0] = status_reg;
         `CT_OFS_MASK:   rdata[1:0] = mask_reg;
         `CT_OFS_TRIG:   rdata[0] = pulse_reg;
         default:        rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= rd_start;
         if (rd_start) begin
            dat_reg <= rdata;
         end
      end
   end

   assign wb_ack_o   = ack_reg;
   assign wb_dat_o   = dat_reg;
   assign ctrl_wdata = merge({19'h0, ctrl_reg}, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `CT_CTRL_RST;
         mask_reg <= `CT_MASK_RST;
      end else if (wr_fire) begin
         if (wb_adr_i == `CT_OFS_CTRL) begin
            ctrl_reg <= ctrl_s'(ctrl_wdata[`CT_CTRL_W-1:0]);
         end
         if (wb_adr_i == `CT_OFS_MASK && wb_sel_i[0]) begin
            mask_reg <= wb_dat_i[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, prescaler and count clock edges

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_sync_reg <= 2'h0;
         b_sync_reg <= 2'h0;
      end else begin
         a_sync_reg <= {a_sync_reg[0], capture_input_a_i};
         b_sync_reg <= {b_sync_reg[0], capture_input_b_i};
      end
   end

   assign run         = ctrl_reg.op_mode != `CT_MODE_STOP;
   assign half_period = 3'((4'h1 << ctrl_reg.prm) - 4'h1);
   assign half_tick   = run && div_reg == half_period;
   assign rise_tick   = half_tick & ~cclk_reg;
   assign fall_tick   = half_tick & cclk_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         div_reg  <= 3'h0;
         cclk_reg <= 1'b0;
      end else if (half_tick) begin
         div_reg  <= 3'h0;
         cclk_reg <= ~cclk_reg;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end

   // Input a sampled on the base clock when it drives the count
   assign samp_en_a = ctrl_reg.ext_clk ? 1'b1 : rise_tick;

   edge_filter u_filter_a (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .pin_i       (a_sync_reg[1]),
      .sample_en_i (samp_en_a),
      .run_i       (run),
      .edges_o     (edges_a)
   );

   edge_filter u_filter_b (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .pin_i       (b_sync_reg[1]),
      .sample_en_i (rise_tick),
      .run_i       (run),
      .edges_o     (edges_b)
   );

   assign valid_a = edge_match(ctrl_reg.esa, edges_a);
   assign rev_a   = edge_match(ctrl_reg.esa ^ 2'h1, edges_a) & ~ctrl_reg.esa[1];
   assign valid_b = edge_match(ctrl_reg.esb, edges_b);

   ////////////////////////////////////////////////////////////////////////
   // Capture triggers and capture pipeline

   assign trig_cap_b   = valid_a & ctrl_reg.capb_en & ~ctrl_reg.ext_clk;
   assign trig_cap_a   = ctrl_reg.capa_en &
                         (ctrl_reg.phase ? rev_a & ~ctrl_reg.ext_clk
                                         : valid_b);
   assign direct_irq_a = ctrl_reg.phase & valid_b;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_a_pend_reg <= 1'b0;
         cap_b_pend_reg <= 1'b0;
         irq_a_pend_reg <= 1'b0;
         irq_b_pend_reg <= 1'b0;
         capture_irq_a  <= 1'b0;
         capture_irq_b  <= 1'b0;
      end else begin
         capture_irq_a <= irq_a_pend_reg & rise_tick;
         capture_irq_b <= irq_b_pend_reg & rise_tick;
         if (trig_cap_a) begin
            cap_a_pend_reg <= 1'b1;
         end else if (fall_tick) begin
            cap_a_pend_reg <= 1'b0;
         end
         if (trig_cap_b) begin
            cap_b_pend_reg <= 1'b1;
         end else if (fall_tick) begin
            cap_b_pend_reg <= 1'b0;
         end
         // Reverse-phase latch into register a queues no interrupt
         if ((fall_tick && cap_a_pend_reg && !ctrl_reg.phase) || direct_irq_a) begin
            irq_a_pend_reg <= 1'b1;
         end else if (rise_tick) begin
            irq_a_pend_reg <= 1'b0;
         end
         if (fall_tick && cap_b_pend_reg) begin
            irq_b_pend_reg <= 1'b1;
         end else if (rise_tick) begin
            irq_b_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_compare_reg_a <= `CT_CAP_RST;
         capture_compare_reg_b <= `CT_CAP_RST;
      end else begin
         if (fall_tick && cap_a_pend_reg) begin
            capture_compare_reg_a <= timer_count_value;
         end else if (wr_fire && wb_adr_i == `CT_OFS_CAP_A) begin
            capture_compare_reg_a <= 16'(merge({16'h0, capture_compare_reg_a},
                                               wb_dat_i, wb_sel_i));
         end
         if (fall_tick && cap_b_pend_reg) begin
            capture_compare_reg_b <= timer_count_value;
         end else if (wr_fire && wb_adr_i == `CT_OFS_CAP_B) begin
            capture_compare_reg_b <= 16'(merge({16'h0, capture_compare_reg_b},
                                               wb_dat_i, wb_sel_i));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter

   assign cnt_tick = ctrl_reg.ext_clk ? valid_a : rise_tick;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         timer_count_value <= 16'h0000;
         started_reg       <= 1'b0;
      end else begin
         case (ctrl_reg.op_mode)
            `CT_MODE_A_START: begin
               if (valid_a) begin
                  started_reg       <= 1'b1;
                  timer_count_value <= 16'h0000;
               end else if (cnt_tick && started_reg) begin
                  timer_count_value <= timer_count_value + 16'h0001;
               end
            end
            `CT_MODE_MATCH: begin
               if (cnt_tick) begin
                  timer_count_value <= (timer_count_value == capture_compare_reg_a)
                                       ? 16'h0000 : timer_count_value + 16'h0001;
               end
            end
            default: begin
               if (cnt_tick) begin
                  timer_count_value <= timer_count_value + 16'h0001;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One-shot output: active from match b to match a after a trigger

   assign os_mode_ok = ctrl_reg.os_en && (ctrl_reg.op_mode == `CT_MODE_FREE ||
                       ctrl_reg.op_mode == `CT_MODE_A_START);
   assign os_go      = (wr_fire && wb_adr_i == `CT_OFS_TRIG && wb_sel_i[0] &&
                        wb_dat_i[0]) ||
                       (ctrl_reg.op_mode == `CT_MODE_A_START && valid_a);

   always_ff @(posedge clk_i) begin
      if (rst_i || !os_mode_ok) begin
         armed_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end else if (os_go && !armed_reg) begin
         armed_reg <= 1'b1;
      end else if (armed_reg && cnt_tick) begin
         if (timer_count_value == capture_compare_reg_a && pulse_reg) begin
            pulse_reg <= 1'b0;
            armed_reg <= 1'b0;
         end else if (timer_count_value == capture_compare_reg_b) begin
            pulse_reg <= 1'b1;
         end
      end
   end

   assign pulse_o = pulse_reg;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output; a new event beats a clear

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= 2'h0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~((wr_fire && wb_adr_i == `CT_OFS_STATUS &&
                                        wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0))
                       | {capture_irq_b, capture_irq_a};
         irq_reg    <= |(status_reg & mask_reg);
      end
   end

   assign irq_o = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_oneshot_mode_gate: assert property ($rose(pulse_reg) |-> $past(os_mode_ok))
      else $error("One-shot output rose in a disallowed mode");
   a_ext_no_self: assert property (ctrl_reg.ext_clk && !cap_b_pend_reg &&
      !(wr_fire && wb_adr_i == `CT_OFS_CAP_B) |=> $stable(capture_compare_reg_b))
      else $error("Input a captured while it drives the count");
   a_capture_on_fall: assert property (
      $past(cap_b_pend_reg && fall_tick) |-> capture_compare_reg_b ==
      $past(timer_count_value))
      else $error("Capture b not latched on count clock fall");
   a_irq_on_rise: assert property ($rose(status_reg[`CT_IRQ_B]) |->
      $past(rise_tick, 2) && $past(irq_b_pend_reg, 2))
      else $error("Capture b interrupt not tied to count clock rise");
   a_reverse_no_irq: assert property (
      ctrl_reg.phase && !direct_irq_a |=> !$rose(irq_a_pend_reg))
      else $error("Reverse-phase capture raised interrupt a");
   a_b_edge_irq_a: assert property (ctrl_reg.phase && valid_b |=>
      irq_a_pend_reg && $stable(capture_compare_reg_a))
      else $error("Input b edge mishandled in reverse phase");
   a_sample_base: assert property (ctrl_reg.ext_clk |-> samp_en_a)
      else $error("Count-clock input not sampled every base cycle");
   a_sample_count: assert property (!ctrl_reg.ext_clk |-> samp_en_a == rise_tick)
      else $error("Trigger input not sampled on count clock");
   a_stopped_quiet: assert property (!run ##1 !run |-> !valid_a && !valid_b)
      else $error("Capture input acknowledged while stopped");
   a_irq_level: assert property (irq_o == $past(|(status_reg & mask_reg)))
      else $error("Interrupt output does not follow masked status");

   c_capture_b: cover property (capture_irq_b);
   c_direct_a: cover property (direct_irq_a);
   c_pulse: cover property ($fell(pulse_reg));
   c_match_wrap: cover property (ctrl_reg.op_mode == `CT_MODE_MATCH && cnt_tick &&
      timer_count_value == capture_compare_reg_a);

endmodule : capture_timer

// ==== capture_timer_consts.svh ====
// Constants for the capture timer: register offsets, field positions,
// reset values and encodings. Included by the capture timer core module.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
//
// Notes on behaviour
// - One-shot output works only in free-running or input-a-start modes.
// - With input-a edge as count clock, captures triggered by input a are blocked.
// - Counter latched on count-clock fall; capture interrupt on the next rise.
// - Reverse-phase capture into register a raises no interrupt a.
// - In reverse phase, input-b edge captures nothing but raises interrupt a.
// - First start after reset treats a high input as a rising edge.
// - Restart after a stop reports no spurious rising edge.
// - Input a used as count clock is sampled on the base clock.
// - Input used as capture trigger is sampled on the prescaled count clock, also when input a drives the count.
// - An edge is recognized after two consecutive samples at the new level.
// - Both capture inputs are ignored while the timer is stopped.
`ifndef CAPTURE_TIMER_CONSTS_SVH
`define CAPTURE_TIMER_CONSTS_SVH

// Register byte offsets
`define CT_OFS_CTRL      8'h00
`define CT_OFS_COUNT     8'h04
`define CT_OFS_CAP_A     8'h08
`define CT_OFS_CAP_B     8'h0C
`define CT_OFS_STATUS    8'h10
`define CT_OFS_MASK      8'h14
`define CT_OFS_TRIG      8'h18

// Control field positions
`define CT_OP_LO         0
`define CT_OP_HI         1
`define CT_PRM_LSB       2
`define CT_ESA_LSB       4
`define CT_ESB_LSB       6
`define CT_PHASE         8
`define CT_CAPA_EN       9
`define CT_CAPB_EN       10
`define CT_EXT_CLK       11
`define CT_OS_EN         12
`define CT_CTRL_W        13

// Status and mask bit positions
`define CT_IRQ_A         0
`define CT_IRQ_B         1

// Reset values
`define CT_CTRL_RST      13'h0000
`define CT_CAP_RST       16'h0000
`define CT_MASK_RST      2'h0

// Operating modes
`define CT_MODE_STOP     2'h0
`define CT_MODE_A_START  2'h1
`define CT_MODE_FREE     2'h2
`define CT_MODE_MATCH    2'h3

// Edge selections
`define CT_ES_FALL       2'h0
`define CT_ES_RISE       2'h1
`define CT_ES_NONE       2'h2
`define CT_ES_BOTH       2'h3

`endif

// ==== capture_timer_pkg.sv ====
// Types shared by the capture timer design files.
// Field order of ctrl_s matches the control field positions.
package capture_timer_pkg;

   typedef logic [15:0] count_t;

   typedef struct packed {
      logic       os_en;
      logic       ext_clk;
      logic       capb_en;
      logic       capa_en;
      logic       phase;
      logic [1:0] esb;
      logic [1:0] esa;
      logic [1:0] prm;
      logic [1:0] op_mode;
   } ctrl_s;

   typedef struct packed {
      logic rise;
      logic fall;
   } edges_s;

endpackage : capture_timer_pkg

// ==== edge_filter.sv ====
// Noise filter and edge detector for one capture input.
// Assumes pin_i is already synchronised to clk_i.
`timescale 1ns/1ps
module edge_filter
   import capture_timer_pkg::*;
(
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   pin_i,
   input  wire logic   sample_en_i,
   input  wire logic   run_i,
   output edges_s      edges_o
);

   logic   fresh_reg;
   logic   prev_reg;
   logic   level_reg;
   edges_s edges_reg;

   assign edges_o = edges_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fresh_reg <= 1'b1;
         prev_reg  <= 1'b0;
         level_reg <= 1'b0;
         edges_reg <= '0;
      end else if (!run_i) begin
         // Inputs ignored while stopped; before the first start the level
         // stays low so a high pin shows as a rise, later it tracks the pin
         edges_reg <= '0;
         prev_reg  <= fresh_reg ? 1'b0 : pin_i;
         level_reg <= fresh_reg ? 1'b0 : pin_i;
      end else begin
         fresh_reg <= 1'b0;
         edges_reg <= '0;
         if (sample_en_i) begin
            prev_reg <= pin_i;
            if (prev_reg == pin_i && pin_i != level_reg) begin
               level_reg      <= pin_i;
               edges_reg.rise <= pin_i;
               edges_reg.fall <= ~pin_i;
            end
         end
      end
   end

   a_edge_two_samples: assert property (@(posedge clk_i) disable iff (rst_i)
      edges_reg.rise |-> level_reg && $past(prev_reg) && $past(pin_i))
      else $error("Rise reported without two high samples");

endmodule : edge_filter

// ==== pulse_source.sv ====
// External pulse source model for the two capture inputs.
// Assumes one-clock fire_i requests; when idle, pin b is driven low and pin a follows level_a_i.
`timescale 1ns/1ps
module pulse_source (
   input  wire logic       clk_i,
   input  wire logic       fire_i,
   input  wire logic       chan_i,
   input  wire logic [7:0] width_i,
   input  wire logic       raw_i,
   input  wire logic       level_a_i,
   output logic            pin_a_o,
   output logic            pin_b_o,
   output logic            busy_o
);
   logic [7:0] left_reg = 8'h00;
   logic       chan_reg = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (fire_i && !busy_o) begin
         chan_reg <= chan_i;
         left_reg <= (raw_i || width_i > 8'h06) ? width_i : 8'h06;
      end else if (busy_o) begin
         left_reg <= left_reg - 8'h01;
      end
   end
   assign busy_o  = (left_reg != 8'h00);
   assign pin_a_o = level_a_i | (busy_o & !chan_reg);
   assign pin_b_o = busy_o & chan_reg;
endmodule : pulse_source

// ==== capture_timer_tb_top.sv ====
// Self-checking bench for the capture timer over classic Wishbone.
// Assumes the pulse_source model drives both capture inputs.
`timescale 1ns/1ps
module capture_timer_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] dat   = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic        pin_a;
   logic        pin_b;
   logic        pulse;
   logic        irq;
   logic        fire  = 1'b0;
   logic        chan  = 1'b0;
   logic [7:0]  wid   = 8'h06;
   logic        raw   = 1'b0;
   logic        lva   = 1'b1;
   logic        busy;
   logic [31:0] rv;
   logic [31:0] cur   = 32'h0;
   logic        hi;
   int          n_fail = 0;
   int          cmp_count = 0;
   always #20 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   capture_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .capture_input_a_i(pin_a), .capture_input_b_i(pin_b),
      .pulse_o(pulse), .irq_o(irq));
   pulse_source u_src (.clk_i(clk_i), .fire_i(fire), .chan_i(chan), .width_i(wid),
      .raw_i(raw), .level_a_i(lva), .pin_a_o(pin_a), .pin_b_o(pin_b), .busy_o(busy));
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rv = rdat;
      if (n >= 20) begin
         n_fail++;
         results();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask : rdc
   // Stop first, then change selects, then start
   task automatic setc(input logic [31:0] c);
      wr(8'h00, cur & ~32'h3);
      wr(8'h00, c & ~32'h3);
      wr(8'h00, c);
      cur = c;
   endtask : setc
   task automatic pls(input logic ch, input logic [7:0] w, input logic r);
      int n;
      @(posedge clk_i);
      fire <= 1'b1;
      chan <= ch;
      wid  <= w;
      raw  <= r;
      @(posedge clk_i);
      fire <= 1'b0;
      @(posedge clk_i);
      n = 0;
      while (busy === 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300) begin
         n_fail++;
         results();
      end
      repeat (40) @(posedge clk_i);
   endtask : pls
   function automatic logic [7:0] rw();
      return 8'h06 + 8'($urandom % 20);
   endfunction : rw
   task automatic endt(input string s);
      $display("test %s finished", s);
   endtask : endt
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk_i);
      n_fail++;
      results();
   end
   initial begin
      void'($urandom(53090));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(8'h00, 32'h0);
      rdc(8'h10, 32'h0);
      rdc(8'h14, 32'h0);
      rdc(8'h1C, 32'h0);
      endt("reset");
      setc(32'h492);
      repeat (40) @(posedge clk_i);
      rdc(8'h10, 32'h2);
      wr(8'h10, 32'h3);
      setc(32'h490);
      setc(32'h492);
      repeat (40) @(posedge clk_i);
      rdc(8'h10, 32'h0);
      setc(32'h490);
      @(posedge clk_i);
      lva <= 1'b0;
      endt("first_start");
      setc(32'h260);
      pls(1'b1, rw(), 1'b0);
      rdc(8'h10, 32'h0);
      wr(8'h08, 32'hFFFF);
      setc(32'h262);
      pls(1'b1, 8'h01, 1'b1);
      rdc(8'h10, 32'h0);
      wr(8'h14, 32'h1);
      pls(1'b1, rw(), 1'b0);
      rdc(8'h10, 32'h1);
      chk(irq, 1'b1);
      bus(1'b0, 8'h08, 32'h0);
      chk(rv[15:0] != 16'hFFFF, 1'b1);
      wr(8'h14, 32'h0);
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b0);
      wr(8'h10, 32'h1);
      setc(32'h26E);
      pls(1'b1, 8'h06, 1'b1);
      rdc(8'h10, 32'h0);
      pls(1'b1, 8'h28, 1'b0);
      rdc(8'h10, 32'h1);
      wr(8'h10, 32'h1);
      endt("capture");
      setc(32'h360);
      wr(8'h08, 32'h1234);
      setc(32'h362);
      pls(1'b1, rw(), 1'b0);
      rdc(8'h10, 32'h1);
      rdc(8'h08, 32'h1234);
      wr(8'h10, 32'h1);
      setc(32'h390);
      wr(8'h08, 32'hFFFF);
      setc(32'h392);
      pls(1'b0, rw(), 1'b0);
      rdc(8'h10, 32'h0);
      bus(1'b0, 8'h08, 32'h0);
      chk(rv[15:0] != 16'hFFFF, 1'b1);
      endt("reverse_phase");
      setc(32'hC9C);
      wr(8'h0C, 32'hFFFF);
      setc(32'hC9E);
      pls(1'b0, 8'h01, 1'b1);
      pls(1'b0, rw(), 1'b0);
      rdc(8'h04, 32'h1);
      rdc(8'h0C, 32'hFFFF);
      wr(8'h04, 32'h55);
      rdc(8'h04, 32'h1);
      endt("count_clock");
      setc(32'h10A0);
      wr(8'h0C, 32'h10);
      wr(8'h08, 32'h30);
      setc(32'h10A2);
      wr(8'h18, 32'h1);
      hi = 1'b0;
      repeat (300) begin
         @(posedge clk_i);
         hi = hi | pulse;
      end
      chk(hi, 1'b1);
      setc(32'h10A3);
      wr(8'h18, 32'h1);
      hi = 1'b0;
      repeat (300) begin
         @(posedge clk_i);
         hi = hi | pulse;
      end
      chk(hi, 1'b0);
      setc(32'h1091);
      pls(1'b0, rw(), 1'b0);
      hi = 1'b0;
      repeat (300) begin
         @(posedge clk_i);
         hi = hi | pulse;
      end
      chk(hi, 1'b1);
      endt("one_shot");
      results();
   end
endmodule : capture_timer_tb_top
